// File: hdl/ifs_top.sv
// Two-wire serial slave that presents the user flash array as an EEPROM.
// Functional notes
// [R1] Bytes are eight bits, serial both ways, at up to 100 kbit/s.
// [R2] Array depth is 128, 256, 512 or 1024 bytes by parameter.
// [R3] Both lines are open drain: pull low or release only.
// [R4] Idle bus leaves both lines released and high.
// [R5] Master starts a transfer only while the bus is free.
// [R6] Data changes only while the clock line is low.
// [R7] Data falling with clock high is start; rising is stop.
// [R8] Only the master makes start and stop; this port never does.
// [R9] Bus busy from start to stop; repeated start acts as start.
// [R10] Master gives a ninth clock; the sender releases data then.
// [R11] Acknowledge holds data low through the ninth clock high phase.
// [R12] A receiver unable to take a byte leaves data high.
// [R13] No acknowledge to new transfers while a program is running.
// [R14] Write-protect input blocks writes, whole array or upper half.
// [R15] Pins give the low three address bits; upper four default 1010. Above 256 bytes the code ignores the low one or two pins.
// [R16] The port is only a slave and behaves as a serial EEPROM.
// [R17] Address byte bit zero: one reads, zero writes.
// [R18] Matching slave address is acknowledged on the ninth clock.
// [R19] Array write begins only at the stop ending the write.
// [R20] Protected write: address bytes acknowledged, first data byte not.
// [R21] Lines are synchronised and glitch filtered before edge detection.
`include "ifs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifs_top #(
  parameter int MEM_DEPTH = `IFS_MEM_DEPTH_DEFAULT,
  parameter int PAGE_BYTES = `IFS_PAGE_BYTES_DEFAULT,
  parameter logic [3:0] ADDR_UPPER = `IFS_ADDR_UPPER_DEFAULT,
  parameter bit WP_UPPER_HALF = 1'b0,
  parameter bit READ_ONLY = 1'b0,
  parameter int PROG_CYCLES = `IFS_PROG_TIME_NS / `IFS_SYS_CLK_NS
) (
  // System side
  input wire logic clock,
  input wire logic sys_rst,
  output logic prog_busy,
  // Link side
  input wire logic link_clk,
  output logic bus_busy,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Straps
  input wire logic wp,
  input wire logic [2:0] addr_select_pins
);
  import ifs_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int XB = (AW > 8) ? AW - 8 : 0;
  localparam logic [9:0] AMASK = 10'(MEM_DEPTH - 1); // [R2]
  localparam logic [9:0] PMASK = 10'(PAGE_BYTES - 1);
  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

  // Reset, pin and program acknowledge synchronisers of the link domain.
  logic rst_m;
  logic link_rst;
  logic [5:0] pin_m;
  logic [5:0] pin_s;
  logic ack_m;
  logic ack_s;
  // Program request crossing into the system domain.
  logic req_m;
  logic req_s;

  ifs_link_s r_reg;
  ifs_link_s r_next;
  ifs_sys_s s_reg;
  ifs_sys_s s_next;

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic buf_we;
  logic commit;
  logic [7:0] rd_byte;

  always_ff @(posedge link_clk) begin
    rst_m <= sys_rst;
    link_rst <= rst_m;
    pin_m <= {wp, addr_select_pins, sda_i, scl_i}; // [R21]
    pin_s <= pin_m;
    ack_m <= s_reg.ack;
    ack_s <= ack_m;
  end

  always_ff @(posedge clock) begin
    req_m <= r_reg.req;
    req_s <= req_m;
  end

  logic scl_now;
  logic sda_now;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic prog_run;
  logic dev_match;
  logic wp_block;

  always_comb begin
    r_next = r_reg;
    buf_we = 1'b0;
    commit = 1'b0;
    rd_byte = mem[r_reg.addr[AW-1:0]];
    for (int i = 0; i < 2; i++) begin
      if (pin_s[i] != r_reg.filt[i]) begin
        if (r_reg.fcnt[i] == `IFS_FILT_LEN - 2'h1) begin
          r_next.filt[i] = pin_s[i]; // [R21]
          r_next.fcnt[i] = 2'h0;
        end else begin
          r_next.fcnt[i] = r_reg.fcnt[i] + 2'h1;
        end
      end else begin
        r_next.fcnt[i] = 2'h0;
      end
    end
    r_next.prev = r_reg.filt;
    scl_now = r_reg.filt[0];
    sda_now = r_reg.filt[1];
    start_c = scl_now && r_reg.prev[0] && r_reg.prev[1] && !sda_now; // [R7]
    stop_c = scl_now && r_reg.prev[0] && !r_reg.prev[1] && sda_now; // [R7]
    scl_rise = scl_now && !r_reg.prev[0];
    scl_fall = !scl_now && r_reg.prev[0];
    prog_run = r_reg.req != ack_s;
    dev_match = r_reg.sh[7:4] == ADDR_UPPER; // [R15]
    for (int i = 0; i < 3; i++) begin
      if (i >= XB && r_reg.sh[i+1] != pin_s[i+2]) begin
        dev_match = 1'b0; // [R15]
      end
    end
    wp_block = READ_ONLY ||
      (pin_s[5] && (!WP_UPPER_HALF || r_reg.addr[AW-1])); // [R14]
    // The port never drives the clock line and never makes start or stop.
    r_next.scl_oe_n = 1'b1; // [R8] [R16]
    r_next.pin_o = 1'b0; // [R3]
    if (stop_c) begin
      r_next.state = IFS_IDLE;
      r_next.bus_busy = 1'b0; // [R9]
      r_next.sda_oe_n = 1'b1; // [R4]
      r_next.vld = 32'h0000_0000;
      if (r_reg.state == IFS_DATA && r_reg.vld != 32'h0000_0000) begin
        commit = 1'b1; // [R19]
        r_next.req = ~r_reg.req;
      end
    end else if (start_c) begin
      // A repeated start restarts decoding like a fresh start.
      r_next.state = IFS_DEV; // [R9]
      r_next.bus_busy = 1'b1; // [R9]
      r_next.cnt = `IFS_BIT_PRE;
      r_next.sda_oe_n = 1'b1;
      r_next.vld = 32'h0000_0000;
    end else if (r_reg.state == IFS_IDLE || r_reg.state == IFS_IGNORE) begin
      r_next.sda_oe_n = 1'b1; // [R4]
    end else if (scl_rise) begin
      if (r_reg.cnt < `IFS_BIT_ACK) begin
        r_next.sh = {r_reg.sh[6:0], sda_now}; // [R1] [R6]
      end else begin
        r_next.nack = sda_now; // [R10]
      end
    end else if (scl_fall) begin
      // All pin changes happen just after a falling clock edge.
      if (r_reg.cnt == `IFS_BIT_PRE) begin
        // The fall that follows a start closes no bit, so it is skipped.
        r_next.cnt = 4'h0; // [R1]
      end else if (r_reg.cnt < `IFS_BIT_LAST) begin
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.state == IFS_READ) begin
          r_next.tx = {r_reg.tx[6:0], 1'b0};
          r_next.sda_oe_n = r_reg.tx[6]; // [R6]
        end
      end else if (r_reg.cnt == `IFS_BIT_LAST) begin
        r_next.cnt = `IFS_BIT_ACK;
        unique case (r_reg.state)
          IFS_DEV: begin
            if (dev_match && !prog_run) begin
              r_next.sda_oe_n = 1'b0; // [R18] [R11] [R13]
              r_next.addr = {r_reg.sh[2:1], r_reg.addr[7:0]} & AMASK;
            end else begin
              r_next.state = IFS_IGNORE; // [R12] [R13]
            end
          end
          IFS_WORD: begin
            r_next.sda_oe_n = 1'b0; // [R11]
            r_next.addr = {r_reg.addr[9:8], r_reg.sh} & AMASK;
          end
          IFS_DATA: begin
            if (wp_block) begin
              // The whole page is dropped, nothing reaches the array.
              r_next.state = IFS_IGNORE; // [R20] [R12]
              r_next.vld = 32'h0000_0000;
            end else begin
              r_next.sda_oe_n = 1'b0; // [R11]
              buf_we = 1'b1;
              r_next.vld[r_reg.addr[4:0] & PMASK[4:0]] = 1'b1;
              r_next.addr = (r_reg.addr & ~PMASK) |
                ((r_reg.addr + 10'h001) & PMASK);
            end
          end
          IFS_READ: begin
            r_next.sda_oe_n = 1'b1; // [R10]
            r_next.addr = (r_reg.addr + 10'h001) & AMASK;
          end
          default: begin
            r_next.state = IFS_IGNORE;
          end
        endcase
      end else begin
        r_next.cnt = 4'h0;
        r_next.sda_oe_n = 1'b1; // [R10]
        unique case (r_reg.state)
          IFS_DEV: begin
            if (r_reg.sh[0]) begin
              r_next.state = IFS_READ; // [R17]
              r_next.tx = rd_byte;
              r_next.sda_oe_n = rd_byte[7];
            end else begin
              r_next.state = IFS_WORD; // [R17]
            end
          end
          IFS_WORD: begin
            r_next.state = IFS_DATA;
          end
          IFS_DATA: begin
            r_next.state = IFS_DATA;
          end
          IFS_READ: begin
            if (r_reg.nack) begin
              r_next.state = IFS_IGNORE;
            end else begin
              r_next.tx = rd_byte;
              r_next.sda_oe_n = rd_byte[7];
            end
          end
          default: begin
            r_next.state = IFS_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      r_reg <= '{state: IFS_IDLE, filt: 2'h3, prev: 2'h3,
                 sda_oe_n: 1'b1, scl_oe_n: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // The array sits on the link clock so reads need no crossing.
  always_ff @(posedge link_clk) begin
    if (buf_we) begin
      pbuf[r_reg.addr[PW-1:0]] <= r_reg.sh;
    end
    if (link_rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= 8'hff;
      end
    end else if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (r_reg.vld[i]) begin
          mem[AW'((r_reg.addr & ~PMASK) | 10'(i))] <= pbuf[i]; // [R19]
        end
      end
    end
  end

  // The program timer runs on the system clock; its end toggles back.
  always_comb begin
    s_next = s_reg;
    if (!s_reg.busy && req_s != s_reg.last) begin
      s_next.busy = 1'b1; // [R13]
      s_next.last = req_s;
      s_next.cnt = PROG_LAST;
    end else if (s_reg.busy) begin
      if (s_reg.cnt == 16'h0000) begin
        s_next.busy = 1'b0;
        s_next.ack = s_reg.last;
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prog_busy = s_reg.busy;
  assign bus_busy = r_reg.bus_busy;
  assign sda_o = r_reg.pin_o;
  assign sda_oe_n = r_reg.sda_oe_n;
  assign scl_o = r_reg.pin_o;
  assign scl_oe_n = r_reg.scl_oe_n;
endmodule
`default_nettype wire

// File: shared/ifs_regs.svh
// Constants of the two-wire flash slave port.
`ifndef IFS_REGS_SVH
`define IFS_REGS_SVH
`define IFS_ADDR_UPPER_DEFAULT 4'ha
`define IFS_MEM_DEPTH_DEFAULT 1024
`define IFS_PAGE_BYTES_DEFAULT 8
`define IFS_SYS_CLK_NS 20
`define IFS_PROG_TIME_NS 100000
`define IFS_FILT_LEN 2'h3
`define IFS_BIT_ACK 4'h8
`define IFS_BIT_LAST 4'h7
`define IFS_BIT_PRE 4'hf
`endif

// File: shared/ifs_pkg.sv
// Types of the two-wire flash slave port.
package ifs_pkg;
  typedef enum logic [2:0] {
    IFS_IDLE = 3'h0,
    IFS_DEV = 3'h1,
    IFS_WORD = 3'h2,
    IFS_DATA = 3'h3,
    IFS_READ = 3'h4,
    IFS_IGNORE = 3'h5
  } ifs_state_e;

  typedef struct packed {
    ifs_state_e state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [9:0] addr;
    logic nack;
    logic [1:0] filt;
    logic [1:0] prev;
    logic [1:0][1:0] fcnt;
    logic [31:0] vld;
    logic bus_busy;
    logic sda_oe_n;
    logic scl_oe_n;
    logic pin_o;
    logic req;
  } ifs_link_s;

  typedef struct packed {
    logic last;
    logic ack;
    logic [15:0] cnt;
    logic busy;
  } ifs_sys_s;
endpackage

// File: test/ifs_checker.sv
// Concurrent checks on the two-wire flash slave port.
`timescale 1ns/1ps
`default_nettype none
module ifs_checker #(
  parameter int PROG_CYCLES = 20
) (
  // System side
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic prog_busy,
  // Link side
  input wire logic link_clk,
  input wire logic bus_busy,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n
);
  // Counts program cycles; a drop of the window clears it.
  logic [15:0] cnt_reg;
  always_ff @(posedge clock) begin
    cnt_reg <= (sys_rst || !prog_busy) ? 16'h0000 : cnt_reg + 16'h0001;
  end
  chk_scl_kept: assert property (@(posedge link_clk)
    disable iff (sys_rst) scl_oe_n) else $error("scl driven");
  chk_sda_low: assert property (@(posedge link_clk)
    disable iff (sys_rst) !sda_o) else $error("sda high");
  chk_scl_low: assert property (@(posedge link_clk)
    disable iff (sys_rst) !scl_o) else $error("scl high");
  chk_idle_free: assert property (@(posedge link_clk)
    disable iff (sys_rst) !bus_busy |-> sda_oe_n) else $error("idle");
  chk_start_busy: assert property (@(posedge link_clk)
    disable iff (sys_rst) scl_i && $fell(sda_i) |-> ##[1:12] bus_busy)
    else $error("no busy");
  chk_stop_free: assert property (@(posedge link_clk)
    disable iff (sys_rst) scl_i && $rose(sda_i) |-> ##[1:12] !bus_busy)
    else $error("no free");
  chk_sda_steady: assert property (@(posedge link_clk)
    disable iff (sys_rst) $changed(sda_oe_n) |-> !scl_i)
    else $error("sda moved");
  chk_prog_nack: assert property (@(posedge clock)
    disable iff (sys_rst) prog_busy |-> sda_oe_n) else $error("ack");
  chk_prog_len: assert property (@(posedge clock)
    disable iff (sys_rst) $fell(prog_busy) |-> cnt_reg == 16'(PROG_CYCLES))
    else $error("length");
endmodule
bind ifs_top ifs_checker #(.PROG_CYCLES(PROG_CYCLES)) ifs_checker_i (
  .clock(clock), .sys_rst(sys_rst), .prog_busy(prog_busy),
  .link_clk(link_clk), .bus_busy(bus_busy), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_n(scl_oe_n));
`default_nettype wire

// File: test/ifs_mst.sv
// Behavioural two-wire bus master facing the slave port.
`timescale 1ns/1ps
`default_nettype none
module ifs_mst (
  // Clock and wire
  input wire logic clock,
  input wire logic sda_w,
  // Lines, high means released
  output logic m_scl,
  output logic m_sda,
  // Ack bit or read byte
  output logic res_v,
  output logic [7:0] res_d
);
  logic r;
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
    res_v = 1'b0;
    res_d = 8'h00;
  end
  // Phases of eight cycles keep each level well past the input filter.
  task automatic ph(input logic s, input logic c);
    m_sda <= s;
    m_scl <= c;
    repeat (8) @(posedge clock);
  endtask
  task automatic cyc(input logic b);
    ph(b, 1'b0);
    ph(b, 1'b1);
    r = sda_w;
    ph(b, 1'b1);
    ph(b, 1'b0);
  endtask
  // Keeps the clock as it is, so it also serves as a repeated start.
  task automatic start();
    ph(1'b1, m_scl);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
    ph(1'b0, 1'b0);
  endtask
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b1);
  endtask
  task automatic put(input logic [7:0] v);
    res_d <= v;
    res_v <= 1'b1;
    @(posedge clock);
    res_v <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) cyc(b[i]);
    cyc(1'b1);
    put({7'h00, r});
  endtask
  task automatic recv();
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      cyc(1'b1);
      d[i] = r;
    end
    put(d);
    cyc(1'b1);
  endtask
endmodule
`default_nettype wire

// File: test/ifs_top_test.sv
// Self-checking bench for the two-wire flash slave port.
`timescale 1ns/1ps
`default_nettype none
module ifs_top_test;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] addr_select_pins = 3'h5;
  logic prog_busy, bus_busy, sda_o, sda_oe_n, scl_o, scl_oe_n;
  logic m_scl, m_sda, res_v;
  logic [7:0] res_d;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];
  logic [7:0] mem[1024];
  wire logic sda_w = m_sda & (sda_oe_n | sda_o);
  wire logic scl_w = m_scl & (scl_oe_n | scl_o);
  always #10 clock = ~clock;
  always #7.5 link_clk = ~link_clk;
  ifs_top #(.PROG_CYCLES(1000)) ifs_top_i (
    .clock(clock), .sys_rst(sys_rst), .prog_busy(prog_busy),
    .link_clk(link_clk), .bus_busy(bus_busy), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .wp(wp), .addr_select_pins(addr_select_pins));
  ifs_mst ifs_mst_i (.clock(clock), .sda_w(sda_w), .m_scl(m_scl),
    .m_sda(m_sda), .res_v(res_v), .res_d(res_d));
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clock) begin
    if (res_v === 1'b1) check(res_d, exp_q.pop_front());
  end
  function automatic logic [7:0] dv(input logic p, input logic rw);
    return {4'ha, addr_select_pins ^ {p, 2'h0}, rw};
  endfunction
  task automatic tx(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    ifs_mst_i.send(b);
  endtask
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    foreach (mem[i]) mem[i] = 8'hff;
    void'($urandom(52));
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom);
      d = 8'($urandom);
      wp <= (k == 2);
      addr_select_pins <= 3'($urandom);
      repeat (20) @(posedge clock);
      ifs_mst_i.start();
      tx(dv(k == 3, 1'b0), {7'h00, k == 3});
      if (k != 3) begin
        tx(a, 8'h00);
        tx(d, {7'h00, k == 2});
        if (k != 2) mem[{addr_select_pins[1:0], a}] = d;
        ifs_mst_i.stop();
        ifs_mst_i.start();
        tx(dv(1'b0, 1'b0), {7'h00, k != 2});
        ifs_mst_i.stop();
        repeat (1000) @(posedge clock);
        ifs_mst_i.start();
        tx(dv(1'b0, 1'b0), 8'h00);
        tx(a, 8'h00);
        ifs_mst_i.start();
        tx(dv(1'b0, 1'b1), 8'h00);
        exp_q.push_back(mem[{addr_select_pins[1:0], a}]);
        ifs_mst_i.recv();
      end
      ifs_mst_i.stop();
    end
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
